/* hw/tbfs_map.svh */
// constants for the triple-port fifo flag block: sizes, widths and synchronised pin counts
// assumes inclusion by bare name from design files under hw/
`ifndef TBFS_MAP_SVH
`define TBFS_MAP_SVH

// memory capacity in words (smallest size option)
`define TBFS_DEPTH     9'h100
// pointer width: one bit above the address for wrap detection
`define TBFS_PTR_W     9
`define TBFS_ADDR_W    8
// narrow port word and wide port word
`define TBFS_WORD_W    18
`define TBFS_WIDE_W    36
// almost-empty / almost-full offset width
`define TBFS_OFS_W     9
// staging buffer on the write-port path
`define TBFS_BUF_DEPTH 4
`define TBFS_BUF_AW    2
// synchronised pin groups
`define TBFS_RD_PINS   4
`define TBFS_WR_PINS   21
`define TBFS_WD_PINS   41

`endif

/* hw/tbfs_pkg.sv */
// types shared by the fifo flag block
// assumes the constants of tbfs_map.svh
package tbfs_pkg;

  // output register state of a fifo in fall-through mode
  typedef enum logic {
    OUT_IDLE,
    OUT_HELD
  } tbfs_out_state_type;

endpackage

/* hw/tbfs_flags.sv */
// fifo read/write ports, mailboxes and clock-synchronised status flags
// assumes all port pins and port clocks are asynchronous to core_clk;
// port clocks are sampled and their rising edges become one-cycle enables
`timescale 1ns/100ps
`include "tbfs_map.svh"

// ==========================================================================
// staging buffer
// ==========================================================================
module tbfs_buffer #(
  parameter int WIDTH = `TBFS_WORD_W,
  parameter int DEPTH = `TBFS_BUF_DEPTH,
  parameter int AW    = `TBFS_BUF_AW
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [AW-1:0]    head_ff;
  logic [AW-1:0]    tail_ff;
  logic [AW:0]      fill_ff;
  logic             push;
  logic             pop;

  // full level at the fill counter's own width
  localparam logic [AW:0] FULL_LVL = DEPTH[AW:0];

  assign inReady  = (fill_ff != FULL_LVL);
  assign outValid = (fill_ff != '0);
  assign outData  = slot_ff[head_ff];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge core_clk)
  begin
    if (push)
      slot_ff[tail_ff] <= inData;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      head_ff <= '0;
      tail_ff <= '0;
      fill_ff <= '0;
    end
    else
    begin
      if (push)
        tail_ff <= tail_ff + 1'b1;
      if (pop)
        head_ff <= head_ff + 1'b1;
      if (push && !pop)
        fill_ff <= fill_ff + 1'b1;
      else if (pop && !push)
        fill_ff <= fill_ff - 1'b1;
    end
  end
endmodule

// ==========================================================================
// one fifo: memory, pointers, output register and flags
// ==========================================================================
module tbfs_fifo_core (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     fwftMode,
  input  wire logic                     wrTick,
  input  wire logic                     wrValid,
  output logic                          wrReady,
  input  wire logic [`TBFS_WORD_W-1:0]  wrData,
  input  wire logic                     rdTick,
  input  wire logic                     rdReq,
  output logic      [`TBFS_WORD_W-1:0]  rdData,
  input  wire logic [`TBFS_OFS_W-1:0]   emptyOffset,
  input  wire logic [`TBFS_OFS_W-1:0]   fullOffset,
  output logic                          emptyOrReady,
  output logic                          almostEmptyN,
  output logic                          fullOrReady,
  output logic                          almostFullN
);
  localparam int PW = `TBFS_PTR_W;

  logic [`TBFS_WORD_W-1:0] mem_ff [1 << `TBFS_ADDR_W];
  logic [PW-1:0]           wrPtr_ff;
  logic [PW-1:0]           wrGray_ff;
  logic [PW-1:0]           rdPtr_ff;
  logic [PW-1:0]           rdGray_ff;
  logic [PW-1:0]           wrSyncA_ff;
  logic [PW-1:0]           wrSyncB_ff;
  logic [PW-1:0]           rdSyncA_ff;
  logic [PW-1:0]           rdSyncB_ff;
  logic [`TBFS_WORD_W-1:0] outReg_ff;
  tbfs_pkg::tbfs_out_state_type outState_ff;
  logic [PW-1:0]           rdCount;
  logic [PW-1:0]           wrCount;
  logic [PW-1:0]           nxt_wrPtr;
  logic [PW-1:0]           nxt_rdPtr;
  logic                    doWrite;
  logic                    rdAccept;
  logic                    doLoad;

  function automatic logic [PW-1:0] toGray(input logic [PW-1:0] b);
    toGray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] fromGray(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--)
      b[i] = (i == PW - 1) ? g[i] : (b[i+1] ^ g[i]);
    fromGray = b;
  endfunction

  // level seen by each side, from its own pointer and the synced far one
  assign rdCount   = fromGray(wrSyncB_ff) - rdPtr_ff;
  assign wrCount   = wrPtr_ff - fromGray(rdSyncB_ff);
  assign nxt_wrPtr = wrPtr_ff + 1'b1;
  assign nxt_rdPtr = rdPtr_ff + 1'b1;

  assign fullOrReady  = (wrCount != `TBFS_DEPTH);
  assign wrReady      = fullOrReady;
  assign almostFullN  = (wrCount < (`TBFS_DEPTH - fullOffset));
  assign almostEmptyN = (rdCount > emptyOffset);
  assign emptyOrReady = fwftMode ? (outState_ff == tbfs_pkg::OUT_HELD)
                                 : (rdCount != '0);
  assign rdData       = outReg_ff;

  assign doWrite  = wrValid && fullOrReady;
  assign rdAccept = rdReq && emptyOrReady;
  // fall-through refills an idle output on its own
  assign doLoad   = rdTick && (rdCount != '0)
                    && (fwftMode ? (outState_ff == tbfs_pkg::OUT_IDLE || rdAccept)
                                 : rdAccept);

  // ==========================================================================
  // write side
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (doWrite)
      mem_ff[wrPtr_ff[`TBFS_ADDR_W-1:0]] <= wrData;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wrPtr_ff  <= '0;
      wrGray_ff <= '0;
    end
    else if (doWrite)
    begin
      wrPtr_ff  <= nxt_wrPtr;
      wrGray_ff <= toGray(nxt_wrPtr);
    end
  end

  // read pointer into the write side, two stages on write edges
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rdSyncA_ff <= '0;
      rdSyncB_ff <= '0;
    end
    else if (wrTick)
    begin
      rdSyncA_ff <= rdGray_ff;
      rdSyncB_ff <= rdSyncA_ff;
    end
  end

  // ==========================================================================
  // read side
  // ==========================================================================
  // write pointer into the read side, two stages on read edges;
  // a write later than the sampling edge is caught by the next one
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wrSyncA_ff <= '0;
      wrSyncB_ff <= '0;
    end
    else if (rdTick)
    begin
      wrSyncA_ff <= wrGray_ff;
      wrSyncB_ff <= wrSyncA_ff;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rdPtr_ff  <= '0;
      rdGray_ff <= '0;
      outReg_ff <= '0;
    end
    else if (doLoad)
    begin
      outReg_ff <= mem_ff[rdPtr_ff[`TBFS_ADDR_W-1:0]];
      rdPtr_ff  <= nxt_rdPtr;
      rdGray_ff <= toGray(nxt_rdPtr);
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      outState_ff <= tbfs_pkg::OUT_IDLE;
    else if (rdTick)
    begin
      case (outState_ff)
        tbfs_pkg::OUT_IDLE:
          if (doLoad && fwftMode)
            outState_ff <= tbfs_pkg::OUT_HELD;
        tbfs_pkg::OUT_HELD:
          if (!fwftMode || (rdAccept && !doLoad))
            outState_ff <= tbfs_pkg::OUT_IDLE;
        default:
          outState_ff <= tbfs_pkg::OUT_IDLE;
      endcase
    end
  end
endmodule

// ==========================================================================
// top: pin synchronisers, port decode, mailboxes
// ==========================================================================
module tbfs_flags (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    first_word_fall_through_mode,
  input  wire logic [`TBFS_OFS_W-1:0]  first_empty_offset,
  input  wire logic [`TBFS_OFS_W-1:0]  first_full_offset,
  input  wire logic [`TBFS_OFS_W-1:0]  secondEmptyOffset,
  input  wire logic [`TBFS_OFS_W-1:0]  secondFullOffset,
  input  wire logic                    wide_port_clock,
  input  wire logic                    widePortSelectN,
  input  wire logic                    widePortWriteNotRead,
  input  wire logic                    widePortEnable,
  input  wire logic                    widePortMailboxSelect,
  input  wire logic [`TBFS_WIDE_W-1:0] widePortDataIn,
  output logic      [`TBFS_WIDE_W-1:0] widePortDataOut,
  output logic                         widePortDataOe,
  output logic                         first_fifo_full_or_in_ready,
  output logic                         first_fifo_almost_full_n,
  output logic                         second_fifo_empty_or_out_ready,
  output logic                         second_fifo_almost_empty_n,
  input  wire logic                    read_port_clock,
  input  wire logic                    read_port_select_n,
  input  wire logic                    read_port_read_enable,
  input  wire logic                    read_port_mailbox_select,
  output logic      [`TBFS_WORD_W-1:0] readPortDataOut,
  output logic                         readPortDataOe,
  output logic                         first_fifo_empty_or_out_ready,
  output logic                         first_fifo_almost_empty_n,
  output logic                         first_mail_full_n,
  input  wire logic                    write_port_clock,
  input  wire logic                    write_port_write_enable,
  input  wire logic                    write_port_mailbox_select,
  input  wire logic [`TBFS_WORD_W-1:0] writePortDataIn,
  output logic                         second_fifo_full_or_in_ready,
  output logic                         second_fifo_almost_full_n,
  output logic                         secondMailFullN
);
  localparam int PINS = `TBFS_RD_PINS + `TBFS_WR_PINS + `TBFS_WD_PINS;

  logic [PINS-1:0]         pinMeta_ff;
  logic [PINS-1:0]         pinSync_ff;
  logic [2:0]              clkPrev_ff;
  logic [PINS-1:0]         pinRaw;
  logic                    rdClkS, rdSelNS, rdEnS, rdMbS;
  logic                    wrClkS, wrEnS, wrMbS;
  logic [`TBFS_WORD_W-1:0] wrDataS;
  logic                    wdClkS, wdSelNS, wdWrS, wdEnS, wdMbS;
  logic [`TBFS_WIDE_W-1:0] wdDataS;
  logic                    rdTick, wrTick, wdTick;
  logic                    rdFifoReq, rdMailReq;
  logic                    wrFifoReq, wrMailReq;
  logic                    wdFifoWr, wdMailWr, wdFifoRd, wdMailRd;
  logic [`TBFS_WORD_W-1:0] mail1_ff;
  logic [`TBFS_WORD_W-1:0] mail2_ff;
  logic                    rdShowMail_ff;
  logic                    wdShowMail_ff;
  logic                    bufInReady;
  logic                    bufOutValid;
  logic                    bufOutReady;
  logic [`TBFS_WORD_W-1:0] bufOutData;
  logic [`TBFS_WORD_W-1:0] fifo1Out;
  logic [`TBFS_WORD_W-1:0] fifo2Out;
  logic                    fifo2FullN;

  assign pinRaw = {read_port_clock, read_port_select_n, read_port_read_enable,
                   read_port_mailbox_select,
                   write_port_clock, write_port_write_enable, write_port_mailbox_select,
                   writePortDataIn,
                   wide_port_clock, widePortSelectN, widePortWriteNotRead, widePortEnable,
                   widePortMailboxSelect, widePortDataIn};

  // two-stage synchroniser for every pin, clocks included
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end
    else
    begin
      pinMeta_ff <= pinRaw;
      pinSync_ff <= pinMeta_ff;
    end
  end

  assign {rdClkS, rdSelNS, rdEnS, rdMbS,
          wrClkS, wrEnS, wrMbS, wrDataS,
          wdClkS, wdSelNS, wdWrS, wdEnS, wdMbS, wdDataS} = pinSync_ff;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      clkPrev_ff <= '0;
    else
      clkPrev_ff <= {rdClkS, wrClkS, wdClkS};
  end

  // rising port-clock edges as one-cycle enables
  assign rdTick = rdClkS && !clkPrev_ff[2];
  assign wrTick = wrClkS && !clkPrev_ff[1];
  assign wdTick = wdClkS && !clkPrev_ff[0];

  // ==========================================================================
  // port decode
  // ==========================================================================
  assign rdFifoReq = !rdSelNS && rdEnS && !rdMbS;
  assign rdMailReq = rdTick && !rdSelNS && rdEnS && rdMbS;
  assign wrFifoReq = wrTick && wrEnS && !wrMbS && fifo2FullN;
  assign wrMailReq = wrTick && wrEnS && wrMbS;
  assign wdFifoWr  = wdTick && !wdSelNS && wdWrS && wdEnS && !wdMbS;
  assign wdMailWr  = wdTick && !wdSelNS && wdWrS && wdEnS && wdMbS;
  assign wdFifoRd  = !wdSelNS && !wdWrS && wdEnS && !wdMbS;
  assign wdMailRd  = wdTick && !wdSelNS && !wdWrS && wdEnS && wdMbS;

  assign second_fifo_full_or_in_ready = fifo2FullN && bufInReady;
  assign readPortDataOe               = !rdSelNS;
  assign widePortDataOe               = !wdSelNS && !wdWrS;

  // ==========================================================================
  // mailboxes and data outputs
  // ==========================================================================
  // a new letter wins over a pickup in the same cycle
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      mail1_ff          <= '0;
      mail2_ff          <= '0;
      first_mail_full_n <= 1'b1;
      secondMailFullN   <= 1'b1;
    end
    else
    begin
      if (wdMailWr)
      begin
        mail1_ff          <= wdDataS[`TBFS_WORD_W-1:0];
        first_mail_full_n <= 1'b0;
      end
      else if (rdMailReq)
        first_mail_full_n <= 1'b1;
      if (wrMailReq)
      begin
        mail2_ff        <= wrDataS;
        secondMailFullN <= 1'b0;
      end
      else if (wdMailRd)
        secondMailFullN <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rdShowMail_ff <= 1'b0;
      wdShowMail_ff <= 1'b0;
    end
    else
    begin
      if (rdMailReq)
        rdShowMail_ff <= 1'b1;
      else if (rdTick && rdFifoReq)
        rdShowMail_ff <= 1'b0;
      if (wdMailRd)
        wdShowMail_ff <= 1'b1;
      else if (wdTick && wdFifoRd)
        wdShowMail_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      readPortDataOut <= '0;
      widePortDataOut <= '0;
    end
    else
    begin
      readPortDataOut <= rdShowMail_ff ? mail1_ff : fifo1Out;
      widePortDataOut <= {{(`TBFS_WIDE_W - `TBFS_WORD_W){1'b0}},
                          (wdShowMail_ff ? mail2_ff : fifo2Out)};
    end
  end

  // ==========================================================================
  // fifos
  // ==========================================================================
  tbfs_fifo_core u_fifo1 (
    .core_clk     (core_clk),
    .reset        (reset),
    .fwftMode     (first_word_fall_through_mode),
    .wrTick       (wdTick),
    .wrValid      (wdFifoWr),
    .wrReady      (),
    .wrData       (wdDataS[`TBFS_WORD_W-1:0]),
    .rdTick       (rdTick),
    .rdReq        (rdFifoReq),
    .rdData       (fifo1Out),
    .emptyOffset  (first_empty_offset),
    .fullOffset   (first_full_offset),
    .emptyOrReady (first_fifo_empty_or_out_ready),
    .almostEmptyN (first_fifo_almost_empty_n),
    .fullOrReady  (first_fifo_full_or_in_ready),
    .almostFullN  (first_fifo_almost_full_n)
  );

  tbfs_buffer #(
    .WIDTH (`TBFS_WORD_W),
    .DEPTH (`TBFS_BUF_DEPTH),
    .AW    (`TBFS_BUF_AW)
  ) u_wr_buffer (
    .core_clk (core_clk),
    .reset    (reset),
    .inValid  (wrFifoReq),
    .inReady  (bufInReady),
    .inData   (wrDataS),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  tbfs_fifo_core u_fifo2 (
    .core_clk     (core_clk),
    .reset        (reset),
    .fwftMode     (first_word_fall_through_mode),
    .wrTick       (wrTick),
    .wrValid      (bufOutValid),
    .wrReady      (bufOutReady),
    .wrData       (bufOutData),
    .rdTick       (wdTick),
    .rdReq        (wdFifoRd),
    .rdData       (fifo2Out),
    .emptyOffset  (secondEmptyOffset),
    .fullOffset   (secondFullOffset),
    .emptyOrReady (second_fifo_empty_or_out_ready),
    .almostEmptyN (second_fifo_almost_empty_n),
    .fullOrReady  (fifo2FullN),
    .almostFullN  (second_fifo_almost_full_n)
  );
endmodule

/* tb/tbfs_flags_assertions.sv */
// checker for the fifo flag block, bound to its top
// assumes pins move 2..3 core cycles ahead of their internal effect
`timescale 1ns/100ps
// ==========================================
// flag and port relations
module tbfs_flags_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic first_word_fall_through_mode,
  input wire logic read_port_clock,
  input wire logic read_port_select_n,
  input wire logic read_port_mailbox_select,
  input wire logic readPortDataOe,
  input wire logic first_fifo_empty_or_out_ready,
  input wire logic first_fifo_almost_empty_n,
  input wire logic first_fifo_full_or_in_ready,
  input wire logic first_fifo_almost_full_n,
  input wire logic wide_port_clock,
  input wire logic first_mail_full_n,
  input wire logic write_port_write_enable,
  input wire logic write_port_mailbox_select,
  input wire logic secondMailFullN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_oe_off;
    read_port_select_n [*4] |-> !readPortDataOe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("read data driven while deselected");
  property p_oe_on;
    !read_port_select_n [*4] |-> readPortDataOe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("read data released while selected");
  property p_ef_ae;
    !first_word_fall_through_mode && first_fifo_almost_empty_n |-> first_fifo_empty_or_out_ready;
  endproperty
  a_ef_ae: assert property (p_ef_ae) else $error("almost-empty high on empty fifo");
  property p_full_af;
    !first_fifo_full_or_in_ready |-> !first_fifo_almost_full_n;
  endproperty
  a_full_af: assert property (p_full_af) else $error("full without almost-full");
  property p_ef_clk;
    $changed(first_fifo_empty_or_out_ready) |->
      $past(read_port_clock, 2) || $past(read_port_clock, 3);
  endproperty
  a_ef_clk: assert property (p_ef_clk) else $error("empty flag moved off read edge");
  property p_af_clk;
    $changed(first_fifo_almost_full_n) |->
      $past(wide_port_clock, 2) || $past(wide_port_clock, 3);
  endproperty
  a_af_clk: assert property (p_af_clk) else $error("almost-full moved off wide edge");
  property p_mail1;
    $rose(first_mail_full_n) |-> $past(read_port_mailbox_select, 3);
  endproperty
  a_mail1: assert property (p_mail1) else $error("mail flag cleared without mail read");
  property p_mail2;
    $fell(secondMailFullN) |->
      $past(write_port_mailbox_select, 3) && $past(write_port_write_enable, 3);
  endproperty
  a_mail2: assert property (p_mail2) else $error("mail flag set without mail write");
endmodule

bind tbfs_flags tbfs_flags_checker chk (
  .core_clk                      (core_clk),
  .reset                         (reset),
  .first_word_fall_through_mode  (first_word_fall_through_mode),
  .read_port_clock               (read_port_clock),
  .read_port_select_n            (read_port_select_n),
  .read_port_mailbox_select      (read_port_mailbox_select),
  .readPortDataOe                (readPortDataOe),
  .first_fifo_empty_or_out_ready (first_fifo_empty_or_out_ready),
  .first_fifo_almost_empty_n     (first_fifo_almost_empty_n),
  .first_fifo_full_or_in_ready   (first_fifo_full_or_in_ready),
  .first_fifo_almost_full_n      (first_fifo_almost_full_n),
  .wide_port_clock               (wide_port_clock),
  .first_mail_full_n             (first_mail_full_n),
  .write_port_write_enable       (write_port_write_enable),
  .write_port_mailbox_select     (write_port_mailbox_select),
  .secondMailFullN               (secondMailFullN)
);

/* tb/tbfs_port_master.sv */
// bus master standing on one port of the fifo block
// assumes one call at a time; port clock period 320 ns
`timescale 1ns/100ps
// ==========================================
// port master
module tbfs_port_master (
  output logic        pclk,
  output logic        selN,
  output logic        en,
  output logic        mb,
  output logic        wnr,
  output logic [17:0] d
);
  initial {pclk, selN, en, mb, wnr, d} = '0;
  // one port cycle: controls move while the clock is low, held over the rise
  task automatic cyc(input logic s, e, m, w, input logic [17:0] v);
    selN = s;
    en   = e;
    mb   = m;
    wnr  = w;
    d    = (e & w) ? v : ~d;
    #167 pclk = 1'h1;
    #153 pclk = 1'h0;
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench of the fifo flag block
// assumes the partner masters drive all three ports
`timescale 1ns/100ps
// ==========================================
// bench
module testbench;
  logic        core_clk, reset, first_word_fall_through_mode;
  logic [8:0]  first_empty_offset = 9'h002, first_full_offset = 9'h002;
  logic [8:0]  secondEmptyOffset = 9'h002, secondFullOffset = 9'h002;
  logic [35:0] widePortDataOut;
  logic [17:0] readPortDataOut;
  logic        widePortDataOe, first_fifo_full_or_in_ready, first_fifo_almost_full_n;
  logic        second_fifo_empty_or_out_ready, second_fifo_almost_empty_n, readPortDataOe;
  logic        first_fifo_empty_or_out_ready, first_fifo_almost_empty_n, first_mail_full_n;
  logic        second_fifo_full_or_in_ready, second_fifo_almost_full_n, secondMailFullN;
  wire         wide_port_clock, widePortSelectN, widePortWriteNotRead, widePortEnable;
  wire         widePortMailboxSelect, read_port_clock, read_port_select_n;
  wire         read_port_read_enable, read_port_mailbox_select, write_port_clock;
  wire         write_port_write_enable, write_port_mailbox_select;
  wire  [17:0] wideLow, writePortDataIn;
  wire  [35:0] widePortDataIn = {18'h0, wideLow};
  int          fails, tests_run, wv, i;

  tbfs_port_master wa (.pclk(wide_port_clock), .selN(widePortSelectN), .en(widePortEnable),
    .mb(widePortMailboxSelect), .wnr(widePortWriteNotRead), .d(wideLow));
  tbfs_port_master rb (.pclk(read_port_clock), .selN(read_port_select_n),
    .en(read_port_read_enable), .mb(read_port_mailbox_select), .wnr(), .d());
  tbfs_port_master wc (.pclk(write_port_clock), .selN(), .en(write_port_write_enable),
    .mb(write_port_mailbox_select), .wnr(), .d(writePortDataIn));
  tbfs_flags dut (.*);

  always #20 core_clk = ~core_clk;

  task automatic chk(input logic [17:0] a, e);
    repeat (2) @(posedge core_clk);
    #1 tests_run++;
    if (a !== e)
    begin
      fails++;
      $display("CHECK FAILED %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic chkf(input logic a, e);
    chk({17'h0, a}, {17'h0, e});
  endtask
  task automatic rst(input logic m);
    reset = 1'h1;
    first_word_fall_through_mode = m;
    repeat (4) @(posedge core_clk);
    #1 reset = 1'h0;
    repeat (3) @(posedge core_clk);
    #1 wv = 0;
  endtask
  task automatic wr(input int n);
    repeat (n)
    begin
      wv++;
      wa.cyc(1'h0, 1'h1, 1'h0, 1'h1, wv[17:0]);
    end
  endtask
  task automatic rdi(input int n);
    repeat (n) rb.cyc(1'h0, 1'h0, 1'h0, 1'h0, 18'h0);
  endtask
  task automatic wi(input int n);
    repeat (n) wa.cyc(1'h0, 1'h0, 1'h0, 1'h1, 18'h0);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'h0;
    fails = 0;
    tests_run = 0;
    rst(1'h0);
    chkf(first_fifo_full_or_in_ready, 1'h1);
    chkf(second_fifo_full_or_in_ready, 1'h1);
    chkf(second_fifo_almost_full_n, 1'h1);
    chkf(second_fifo_almost_empty_n, 1'h0);
    rb.cyc(1'h0, 1'h1, 1'h0, 1'h0, 18'h0);
    chk(readPortDataOut, 18'h0);
    chkf(readPortDataOe, 1'h1);
    wr(1);
    rdi(1);
    chkf(first_fifo_empty_or_out_ready, 1'h0);
    rdi(1);
    chkf(first_fifo_empty_or_out_ready, 1'h1);
    wr(1);
    rdi(2);
    chkf(first_fifo_almost_empty_n, 1'h0);
    wr(1);
    rdi(2);
    chkf(first_fifo_almost_empty_n, 1'h1);
    wr(250);
    wi(1);
    chkf(first_fifo_almost_full_n, 1'h1);
    wr(1);
    wi(1);
    chkf(first_fifo_almost_full_n, 1'h0);
    wr(2);
    wi(1);
    chkf(first_fifo_full_or_in_ready, 1'h0);
    wr(1);
    rb.cyc(1'h0, 1'h1, 1'h0, 1'h0, 18'h0);
    chk(readPortDataOut, 18'h1);
    wi(1);
    chkf(first_fifo_full_or_in_ready, 1'h0);
    wi(1);
    chkf(first_fifo_full_or_in_ready, 1'h1);
    for (i = 2; i <= 256; i++)
    begin
      rb.cyc(1'h0, 1'h1, 1'h0, 1'h0, 18'h0);
      chk(readPortDataOut, i[17:0]);
    end
    rdi(2);
    rb.cyc(1'h0, 1'h1, 1'h0, 1'h0, 18'h0);
    chk(readPortDataOut, 18'h100);
    $display("test fill and drain done");
    wa.cyc(1'h0, 1'h1, 1'h1, 1'h1, 18'h2A5A5);
    chkf(first_mail_full_n, 1'h0);
    rb.cyc(1'h0, 1'h1, 1'h1, 1'h0, 18'h0);
    chk(readPortDataOut, 18'h2A5A5);
    chkf(first_mail_full_n, 1'h1);
    rb.cyc(1'h1, 1'h0, 1'h0, 1'h0, 18'h0);
    chkf(readPortDataOe, 1'h0);
    $display("test read port done");
    wc.cyc(1'h0, 1'h0, 1'h0, 1'h1, 18'h01234);
    wi(2);
    chkf(second_fifo_empty_or_out_ready, 1'h0);
    wc.cyc(1'h0, 1'h1, 1'h1, 1'h1, 18'h3C3C3);
    chkf(secondMailFullN, 1'h0);
    wa.cyc(1'h0, 1'h1, 1'h1, 1'h0, 18'h0);
    chk(widePortDataOut[17:0], 18'h3C3C3);
    wc.cyc(1'h0, 1'h1, 1'h0, 1'h1, 18'h00055);
    wi(2);
    chkf(second_fifo_empty_or_out_ready, 1'h1);
    wa.cyc(1'h0, 1'h1, 1'h0, 1'h0, 18'h0);
    chk(widePortDataOut[17:0], 18'h00055);
    chkf(widePortDataOe, 1'h1);
    $display("test write port done");
    rst(1'h1);
    wr(1);
    rdi(2);
    chkf(first_fifo_empty_or_out_ready, 1'h0);
    rdi(1);
    chkf(first_fifo_empty_or_out_ready, 1'h1);
    chk(readPortDataOut, 18'h1);
    $display("test fall-through done");
    print_verdict();
  end

  initial
  begin
    #600000 fails++;
    $display("CHECK FAILED %0t timeout", $time);
    print_verdict();
  end
endmodule
